/* rtl/sltx_defs.vh */
// register map, field positions, reset values and timing constants
`ifndef SLTX_DEFS_VH
`define SLTX_DEFS_VH

// ----------------------------------------------------------------
// register byte addresses (low 16 bits decoded)
// ----------------------------------------------------------------
`define SLTX_ADDR_CTRL        32'hfffd0000
`define SLTX_ADDR_DATA        32'hfffd0004

// ----------------------------------------------------------------
// control word field positions
// ----------------------------------------------------------------
`define SLTX_BIT_EN           0
`define SLTX_BIT_MODE         1
`define SLTX_BIT_STROBE       2
`define SLTX_PRSC_LO          3
`define SLTX_PRSC_HI          5
`define SLTX_BUFS_LO          6
`define SLTX_BUFS_HI          9
`define SLTX_TTOT_LO          10
`define SLTX_TTOT_HI          14
`define SLTX_TZERO_LO         15
`define SLTX_TZERO_HI         19
`define SLTX_TONE_LO          20
`define SLTX_TONE_HI          24
`define SLTX_BIT_IRQCONF      27
`define SLTX_BIT_EMPTY        28
`define SLTX_BIT_HALF         29
`define SLTX_BIT_FULL         30
`define SLTX_BIT_BUSY         31

// ----------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------
`define SLTX_CTRL_RESET       32'h00000000
`define SLTX_STROBE_PERIODS   7'h7f
`define SLTX_PRSC_F0          12'h001
`define SLTX_PRSC_F1          12'h003
`define SLTX_PRSC_F2          12'h007
`define SLTX_PRSC_F3          12'h03f
`define SLTX_PRSC_F4          12'h07f
`define SLTX_PRSC_F5          12'h3ff
`define SLTX_PRSC_F6          12'h7ff
`define SLTX_PRSC_F7          12'hfff

`endif

/* rtl/sltx_fifo.v */
// small flop-based fifo holding queued transmit entries
`timescale 1ns/1ps

module sltx_fifo
#(
    parameter WIDTH = 34,
    parameter AW    = 0
)
(
    // clock and reset
    input  wire             hclk,
    input  wire             hresetn,
    input  wire             clear,
    // write side
    input  wire             wr_valid,
    input  wire [WIDTH-1:0] wr_data,
    output wire             wr_ready,
    // read side
    input  wire             rd_ready,
    output wire             rd_valid,
    output wire [WIDTH-1:0] rd_data,
    // fill level
    output wire             empty,
    output wire             full,
    output wire             half
);
    localparam DEPTH = 1 << AW;

    // ----------------------------------------------------------------
    // storage and pointers (one extra pointer bit tells full from empty)
    // ----------------------------------------------------------------
    reg  [WIDTH-1:0] mem [0:DEPTH-1];  // entry storage
    reg  [AW:0]      wptr;             // write pointer
    reg  [AW:0]      rptr;             // read pointer
    wire [AW:0]      level;            // entries held
    wire             do_wr;
    wire             do_rd;
    integer          i;

    assign level    = wptr - rptr;
    assign empty    = (wptr == rptr);
    assign full     = (level == DEPTH[AW:0] + {(AW+1){1'b0}}) | (DEPTH == 1 && !empty);
    assign half     = ({1'b0, level} >= ({1'b0, DEPTH[AW:0]} >> 1)) && !empty;
    assign wr_ready = !full;
    assign rd_valid = !empty;
    assign do_wr    = wr_valid && !full;
    assign do_rd    = rd_ready && !empty;
    assign rd_data  = mem[rptr[AW-1+(AW==0):0] & (DEPTH-1)];

    // pointer update; clear drops every entry at once
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wptr <= {(AW+1){1'b0}};
            rptr <= {(AW+1){1'b0}};
        end
        else if (clear)
        begin
            wptr <= {(AW+1){1'b0}};
            rptr <= {(AW+1){1'b0}};
        end
        else
        begin
            if (do_wr)
                wptr <= wptr + 1'b1;
            if (do_rd)
                rptr <= rptr + 1'b1;
        end
    end

    // data storage, no reset needed since empty guards reads
    always @(posedge hclk)
    begin
        if (do_wr)
            mem[wptr[AW-1+(AW==0):0] & (DEPTH-1)] <= wr_data;
    end
endmodule

/* rtl/sltx_top.v */
// smart led serial transmitter with ahb-lite register slave
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "sltx_defs.vh"

// Function
// [RULE1] tick period is clock times prescaler
// [RULE2] prescaler select in control bits 5:3
// [RULE3] bit period equals total-ticks field
// [RULE4] zero bit high for zero-high ticks
// [RULE5] one bit high for one-high ticks
// [RULE6] buffer depth parameter, log2 readable
// [RULE7] data write queues, engine drains queue
// [RULE8] word size stored with each entry
// [RULE9] 24 or 32 bits sent; data write-only
// [RULE10] status bits empty, half, full
// [RULE11] busy bit while engine sends
// [RULE12] software keeps timing fixed while active
// [RULE13] latch entry drives low 127 periods
// [RULE14] latch flag queued with each entry
// [RULE15] interrupt only while block enabled
// [RULE16] irq on less-than-half or empty
// [RULE17] interrupt is level, no clear
// [RULE18] disable aborts, flushes, output low
// [RULE19] prescaler codes map to fixed factors
// [RULE20] words shifted least significant first
// [RULE21] high at period start, then low
// [RULE22] enable bit 0; idle output low
module sltx_top
#(
    parameter FIFO_LOG2 = 0
)
(
    // ahb-lite clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // led chain and interrupt
    output reg         led_serial_out,
    output reg         irq
);
    // ----------------------------------------------------------------
    // engine states
    // ----------------------------------------------------------------
    localparam ST_IDLE  = 2'b00;  // waiting for an entry
    localparam ST_BIT   = 2'b01;  // sending a data bit
    localparam ST_LATCH = 2'b10;  // holding the line low

    // full byte addresses; only the low half is decoded
    localparam [31:0] CTRL_ADDR = `SLTX_ADDR_CTRL;
    localparam [31:0] DATA_ADDR = `SLTX_ADDR_DATA;

    // ----------------------------------------------------------------
    // bus address phase capture
    // ----------------------------------------------------------------
    reg         dp_wr;     // data phase is a write
    reg         dp_rd;     // data phase is a read
    reg  [15:0] dp_addr;   // latched low address bits
    wire        ap_valid;

    assign ap_valid = hsel && hready && htrans[1];

    // latch the address phase; slave is always ready, always okay
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_wr     <= 1'b0;
            dp_rd     <= 1'b0;
            dp_addr   <= 16'h0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            dp_wr     <= ap_valid && hwrite;
            dp_rd     <= ap_valid && !hwrite;
            dp_addr   <= haddr[15:0];
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    reg         en;          // block enable
    reg         mode32;      // word size for new entries
    reg         strobe;      // latch request for new entries
    reg  [2:0]  tick_divider_select;
    reg  [4:0]  bit_period_ticks;
    reg  [4:0]  zero_high_ticks;
    reg  [4:0]  one_high_ticks;
    reg         irq_level_select;
    wire        wr_ctrl;
    wire        wr_data;
    wire [3:0]  buffer_depth_log2;

    assign wr_ctrl = dp_wr && (dp_addr == CTRL_ADDR[15:0]);
    assign wr_data = dp_wr && (dp_addr == DATA_ADDR[15:0]);
    assign buffer_depth_log2 = FIFO_LOG2[3:0];  // RULE6

    // software writes to the writable control fields
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            en                  <= 1'b0;
            mode32              <= 1'b0;
            strobe              <= 1'b0;
            tick_divider_select <= 3'h0;
            bit_period_ticks    <= 5'h00;
            zero_high_ticks     <= 5'h00;
            one_high_ticks      <= 5'h00;
            irq_level_select    <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            en                  <= hwdata[`SLTX_BIT_EN];  // RULE22
            mode32              <= hwdata[`SLTX_BIT_MODE];
            strobe              <= hwdata[`SLTX_BIT_STROBE];
            // RULE2
            tick_divider_select <= hwdata[`SLTX_PRSC_HI:`SLTX_PRSC_LO];
            bit_period_ticks    <= hwdata[`SLTX_TTOT_HI:`SLTX_TTOT_LO];
            zero_high_ticks     <= hwdata[`SLTX_TZERO_HI:`SLTX_TZERO_LO];
            one_high_ticks      <= hwdata[`SLTX_TONE_HI:`SLTX_TONE_LO];
            irq_level_select    <= hwdata[`SLTX_BIT_IRQCONF];
        end
    end

    // ----------------------------------------------------------------
    // transmit buffer: {latch, size, word}
    // ----------------------------------------------------------------
    wire        f_empty;
    wire        f_full;
    wire        f_half;
    wire        f_valid;
    wire [33:0] f_data;
    reg         f_pop;
    reg  [1:0]  state;

    // a write while disabled is dropped, the buffer is held flushed
    sltx_fifo
    #(
        .WIDTH (34),
        .AW    (FIFO_LOG2)
    )
    u_fifo
    (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .clear    (!en),                             // RULE18
        .wr_valid (wr_data && en),                   // RULE7
        .wr_data  ({strobe, mode32, hwdata}),        // RULE8 RULE14
        .wr_ready (),
        .rd_ready (f_pop),
        .rd_valid (f_valid),
        .rd_data  (f_data),
        .empty    (f_empty),
        .full     (f_full),
        .half     (f_half)
    );

    // ----------------------------------------------------------------
    // tick generator
    // ----------------------------------------------------------------
    reg  [11:0] pre_cnt;   // main clock divider count
    reg  [11:0] pre_max;   // terminal count for the chosen factor
    reg         tick;      // one-cycle transmit tick

    // division factor lookup
    always @*
    begin
        case (tick_divider_select)  // RULE19
            3'h0:    pre_max = `SLTX_PRSC_F0;
            3'h1:    pre_max = `SLTX_PRSC_F1;
            3'h2:    pre_max = `SLTX_PRSC_F2;
            3'h3:    pre_max = `SLTX_PRSC_F3;
            3'h4:    pre_max = `SLTX_PRSC_F4;
            3'h5:    pre_max = `SLTX_PRSC_F5;
            3'h6:    pre_max = `SLTX_PRSC_F6;
            default: pre_max = `SLTX_PRSC_F7;
        endcase
    end

    // divider runs only while enabled so ticks restart aligned
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pre_cnt <= 12'h000;
            tick    <= 1'b0;
        end
        else if (!en)
        begin
            pre_cnt <= 12'h000;
            tick    <= 1'b0;
        end
        else if (pre_cnt >= pre_max)
        begin
            pre_cnt <= 12'h000;
            tick    <= 1'b1;  // RULE1
        end
        else
        begin
            pre_cnt <= pre_cnt + 12'h001;
            tick    <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // serial engine
    // ----------------------------------------------------------------
    reg  [31:0] shreg;     // word being shifted out
    reg  [5:0]  bits_left; // data bits still to send
    reg  [4:0]  tcnt;      // tick within the bit period
    reg  [6:0]  pcnt;      // latch periods done
    reg         busy;
    wire [4:0]  hi_ticks;

    assign hi_ticks = shreg[0] ? one_high_ticks : zero_high_ticks;

    // pop one entry, then send it bit by bit or as a low latch
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state          <= ST_IDLE;
            shreg          <= 32'h00000000;
            bits_left      <= 6'h00;
            tcnt           <= 5'h00;
            pcnt           <= 7'h00;
            busy           <= 1'b0;
            f_pop          <= 1'b0;
            led_serial_out <= 1'b0;
        end
        else if (!en)
        begin
            state          <= ST_IDLE;  // RULE18
            busy           <= 1'b0;
            f_pop          <= 1'b0;
            led_serial_out <= 1'b0;
        end
        else
        begin
            f_pop <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    led_serial_out <= 1'b0;  // RULE22
                    // f_pop guard keeps the same entry from double pop
                    if (f_valid && !f_pop)
                    begin
                        f_pop <= 1'b1;  // RULE7
                        busy  <= 1'b1;  // RULE11
                        tcnt  <= 5'h00;
                        pcnt  <= 7'h00;
                        shreg <= f_data[31:0];
                        // RULE9
                        bits_left <= f_data[32] ? 6'h20 : 6'h18;
                        state <= f_data[33] ? ST_LATCH : ST_BIT;  // RULE13
                    end
                    else
                        busy <= 1'b0;
                end
                ST_BIT:
                begin
                    if (tick)
                    begin
                        // RULE21 RULE4 RULE5
                        led_serial_out <= (tcnt < hi_ticks);
                        if (tcnt + 5'h01 >= bit_period_ticks)  // RULE3
                        begin
                            tcnt      <= 5'h00;
                            shreg     <= shreg >> 1;  // RULE20
                            bits_left <= bits_left - 6'h01;
                            if (bits_left == 6'h01)
                                state <= ST_IDLE;
                        end
                        else
                            tcnt <= tcnt + 5'h01;
                    end
                end
                ST_LATCH:
                begin
                    led_serial_out <= 1'b0;  // RULE13
                    if (tick)
                    begin
                        if (tcnt + 5'h01 >= bit_period_ticks)
                        begin
                            tcnt <= 5'h00;
                            pcnt <= pcnt + 7'h01;
                            if (pcnt == `SLTX_STROBE_PERIODS - 7'h01)
                                state <= ST_IDLE;
                        end
                        else
                            tcnt <= tcnt + 5'h01;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // interrupt, a plain level with no pending flop
    // ----------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq <= 1'b0;
        else
            // RULE15 RULE16 RULE17
            irq <= en && (irq_level_select ? !f_half : f_empty);
    end

    // ----------------------------------------------------------------
    // read data; data register and unmapped addresses read zero
    // ----------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (ap_valid && !hwrite
                 && haddr[15:0] == CTRL_ADDR[15:0])
        begin
            hrdata <= {busy || !f_empty, f_full, f_half, f_empty,  // RULE10
                       irq_level_select, 2'b00, one_high_ticks,
                       zero_high_ticks, bit_period_ticks,
                       buffer_depth_log2, tick_divider_select,
                       strobe, mode32, en};  // RULE11
        end
        else
            hrdata <= 32'h00000000;  // RULE9
    end
endmodule

/* tb/sltx_top_props.sv */
// bus and serial output checks for the smart led transmitter
`timescale 1ns/1ps

module sltx_props
#(
    parameter FIFO_LOG2 = 0
)
(
    // ahb-lite side
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire [31:0] hrdata,
    // led chain and interrupt
    input wire        led_serial_out,
    input wire        irq
);
    // ----------------------------------------------------------
    // data phase tracking
    // ----------------------------------------------------------
    reg        ph_rd;   // ctrl read data phase
    reg        ph_oth;  // read data phase of any other place
    reg        ph_wc;   // ctrl write data phase
    reg [31:0] shadow;  // last ctrl word written
    wire       take = hsel & hready & htrans[1];
    wire       is_c = haddr[15:0] == 16'h0000;
    wire [31:0] rw_m = 32'h09fffc3f; // writable ctrl bits

    // phases assume zero wait states, as the slave promises
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_rd  <= 1'b0;
            ph_oth <= 1'b0;
            ph_wc  <= 1'b0;
            shadow <= 32'h00000000;
        end
        else
        begin
            ph_rd  <= take & !hwrite & is_c;
            ph_oth <= take & !hwrite & !is_c;
            ph_wc  <= take & hwrite & is_c;
            if (ph_wc)
                shadow <= hwdata;
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    irq_needs_en_a: assert property (
        !shadow[0] [*2] |-> !irq) else $error("irq while disabled");
    out_low_off_a: assert property (
        !shadow[0] [*3] |-> !led_serial_out) else $error("output high");
    ctrl_readback_a: assert property (
        ph_rd |-> (hrdata & rw_m) == (shadow & rw_m))
        else $error("ctrl readback differs");
    depth_field_a: assert property (
        ph_rd |-> hrdata[9:6] == FIFO_LOG2) else $error("depth field");
    data_wo_a: assert property (
        ph_oth |-> hrdata == 32'h00000000) else $error("nonzero read");
    flush_off_a: assert property (
        !shadow[0] [*4] ##1 ph_rd |-> hrdata[31:28] == 4'h1)
        else $error("not flushed while disabled");
    busy_while_out_a: assert property (
        ph_rd && $past(led_serial_out) |-> hrdata[31])
        else $error("busy clear while sending");
    full_is_half_a: assert property (
        ph_rd && hrdata[30] |-> hrdata[29] && !hrdata[28])
        else $error("fill flags disagree");
    irq_level_a: assert property (
        ph_rd && $stable(shadow) && shadow[0]
        |-> irq == (shadow[27] ? !hrdata[29] : hrdata[28]))
        else $error("irq level wrong");
endmodule

bind sltx_top sltx_props #(.FIFO_LOG2(FIFO_LOG2)) props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata),
    .led_serial_out(led_serial_out), .irq(irq));

/* tb/sltx_led_chain.sv */
// led chain model that times every pulse on the serial line
`timescale 1ns/1ps

module sltx_led_chain
(
    // clock and serial line
    input wire hclk,
    input wire din
);
    int   cyc = 0;   // free running clock count
    int   rise_at[$]; // clock count of each rising edge
    int   hi_len[$];  // high time of each pulse in clocks
    int   t_rise = 0; // start of current pulse
    logic last = 0;   // line level at previous edge

    // a pulse is timed rise to fall; period is rise to rise
    always @(posedge hclk)
    begin
        cyc = cyc + 1;
        if (din && !last)
        begin
            rise_at.push_back(cyc);
            t_rise = cyc;
        end
        if (!din && last)
            hi_len.push_back(cyc - t_rise);
        last = din;
    end

    // forget earlier traffic
    task clear;
        rise_at.delete();
        hi_len.delete();
    endtask
endmodule

/* tb/test_smart_led_serial_tx.sv */
// self-checking bench for the smart led transmitter
`timescale 1ns/1ps
`include "sltx_defs.vh"

module test_smart_led_serial_tx;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic        hwrite;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] q;           // last read data
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire         hresp;
    wire         led_serial_out;
    wire         irq;
    int          num_errors = 0;
    int          check_count = 0;
    int          cyc = 0;     // cycles for the hang limit
    int          fac[8] = '{2, 4, 8, 64, 128, 1024, 2048, 4096};
    localparam logic [31:0] CA = `SLTX_ADDR_CTRL;
    localparam logic [31:0] DA = `SLTX_ADDR_DATA;

    // depth four so half and full differ
    sltx_top #(.FIFO_LOG2(2)) dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .led_serial_out(led_serial_out), .irq(irq));
    sltx_led_chain led (.hclk(hclk), .din(led_serial_out));

    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // ----------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] s, e);
        check_count++;
        if (s !== e)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    // one single transfer; read data lands in q
    task automatic xfer(input logic wr, input logic [31:0] a, d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    function automatic logic [31:0] cfg(input int f, p, t, z, o);
        return 32'(f | (p << 3) | (t << 10) | (z << 15) | (o << 20));
    endfunction

    task automatic wait_idle;
        do xfer(1'b0, CA, 0); while (q[31] !== 1'b0);
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task automatic t_regs;
        xfer(1'b0, CA, 0);
        chk("ctrl reset", q, 32'h10000080);
        chk("irq reset", irq, 0);
        xfer(1'b1, CA, 32'hfffffffe);
        xfer(1'b0, CA, 0);
        chk("ctrl fields", q, 32'h19fffcbe);
        xfer(1'b1, DA, 32'h1);
        chk("resp okay", hresp, 0);
        chk("ready", hreadyout, 1);
        xfer(1'b0, DA, 0);
        chk("data read", q, 0);
        xfer(1'b0, CA | 32'h8, 0);
        chk("unmapped", q, 0);
        xfer(1'b0, CA, 0);
        chk("dropped write", q[31:28], 4'h1);
        $display("t_regs done");
    endtask

    // 24 bit then 32 bit word, mode changed between writes
    task automatic t_word;
        logic [55:0] b;
        int i;
        b = {32'h9612ab7f, 24'h5ac396};
        led.clear();
        xfer(1'b1, CA, cfg(1, 0, 6, 2, 4));
        xfer(1'b1, DA, 32'hff5ac396);
        xfer(1'b1, CA, cfg(3, 0, 6, 2, 4));
        xfer(1'b1, DA, 32'h9612ab7f);
        xfer(1'b0, CA, 0);
        chk("busy", q[31], 1);
        wait_idle();
        chk("pulses", led.hi_len.size(), 56);
        for (i = 0; i < 56 && i < led.hi_len.size(); i++)
        begin
            chk("high", led.hi_len[i], b[i] ? 8 : 4);
            if (i != 0 && i != 24)
                chk("period", led.rise_at[i] - led.rise_at[i-1], 12);
        end
        $display("t_word done");
    endtask

    // every divider code, each aborted by disable mid word
    task automatic t_presc;
        int c;
        for (c = 0; c < 8; c++)
        begin
            xfer(1'b1, CA, 0);
            led.clear();
            xfer(1'b1, CA, cfg(1, c, 2, 1, 1));
            xfer(1'b1, DA, 32'h0);
            while (led.rise_at.size() < 2) @(posedge hclk);
            chk("period", led.rise_at[1] - led.rise_at[0], 2 * fac[c]);
            chk("tick high", led.hi_len[0], fac[c]);
            xfer(1'b1, CA, 0);
            repeat (3) @(posedge hclk);
            chk("abort low", led_serial_out, 0);
            xfer(1'b0, CA, 0);
            chk("abort flush", q[31:28], 4'h1);
        end
        $display("t_presc done");
    endtask

    // latch entry queued ahead of a colour word
    task automatic t_latch;
        int t0;
        led.clear();
        xfer(1'b1, CA, cfg(5, 0, 2, 1, 1));
        xfer(1'b1, DA, 32'hffffffff);
        t0 = led.cyc;
        xfer(1'b1, CA, cfg(1, 0, 2, 1, 1));
        xfer(1'b1, DA, 32'h1);
        while (led.rise_at.size() < 1) @(posedge hclk);
        chk("latch gap", (led.rise_at[0] - t0) inside {[508:520]}, 1);
        wait_idle();
        chk("after latch", led.hi_len.size(), 24);
        $display("t_latch done");
    endtask

    // slow engine so the buffer fills
    task automatic t_irq;
        xfer(1'b1, CA, cfg(1, 7, 2, 1, 1));
        repeat (3) @(posedge hclk);
        chk("irq empty", irq, 1);
        repeat (5) @(posedge hclk);
        chk("irq held", irq, 1);
        repeat (5) xfer(1'b1, DA, 32'h0);
        xfer(1'b0, CA, 0);
        chk("fill full", q[31:28], 4'he);
        chk("irq busy", irq, 0);
        xfer(1'b1, CA, cfg(32'h08000001, 7, 2, 1, 1));
        xfer(1'b0, CA, 0);
        chk("irq half", irq, 0);
        xfer(1'b1, CA, cfg(32'h08000000, 7, 2, 1, 1));
        repeat (3) @(posedge hclk);
        chk("irq off", irq, 0);
        xfer(1'b1, CA, cfg(32'h08000001, 7, 2, 1, 1));
        repeat (3) @(posedge hclk);
        chk("irq low fill", irq, 1);
        xfer(1'b1, CA, 0);
        $display("t_irq done");
    endtask

    // ----------------------------------------------------------
    // main sequence and hang limit
    // ----------------------------------------------------------
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h00000000;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_word();
        t_presc();
        t_latch();
        t_irq();
        test_done();
    end

    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            num_errors++;
            $display("ERROR timeout expected done seen hang");
            test_done();
        end
    end
endmodule
